// *** inc/osc_params.svh ***
// constants of the internal oscillator control block
`ifndef OSC_PARAMS_SVH
`define OSC_PARAMS_SVH

// ==========================================================
// register address and bit positions
`define OSC_CTRL_ADDR      8'hb2
`define BIT_EN             7
`define BIT_RDY            6
`define BIT_SUSP           5
`define BIT_SYNC           4
`define BIT_SSE            3
`define BIT_RSVD           2
`define DIV_HI             1
`define DIV_LO             0

// ==========================================================
// reset values
`define RST_EN             1'b1
`define RST_SSE            1'b0
`define RST_DIV            2'h0

// ==========================================================
// post-divider codes
`define DIV_BY8            2'h0
`define DIV_BY4            2'h1
`define DIV_BY2            2'h2
`define DIV_BY1            2'h3

// ==========================================================
// timing
`define CLK_PERIOD_NS      4
`define SETTLE_NS          1000
`define SETTLE_CYC         ((`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SYNC_TIMER_CLKS    2'h3
`define DITHER_STEP_CYC    32
`define DITHER_PERIOD_CYC  384
`define DITHER_PHASES      (`DITHER_PERIOD_CYC / `DITHER_STEP_CYC)

// ==========================================================
// external oscillator mode, upper two bits of the mode field
`define XMODE_OFF          2'h0
`define XMODE_XTAL         2'h3

`endif

// *** inc/osc_pkg.sv ***
// types shared by the internal oscillator control block
package osc_pkg;

	// ==========================================================
	// oscillator life cycle
	typedef enum logic [1:0] {
		OSC_OFF,
		OSC_SETTLE,
		OSC_RUN,
		OSC_SUSP
	} osc_state_t;

	// ==========================================================
	// register bus request
	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} sfr_req_t;

	// ==========================================================
	// software-held control fields
	typedef struct packed {
		logic       en;
		logic       spread_dither_enable;
		logic [1:0] div;
	} ctrl_t;

	typedef struct packed {
		osc_state_t  state;
		ctrl_t       ctrl;
		logic [15:0] settle_cnt;
		logic        ready;
		logic        sync_busy;
		logic [1:0]  sync_cnt;
		logic [2:0]  div_cnt;
		logic        sys_tick;
		logic        run;
		logic [7:0]  rdata;
		logic        in_claim;
		logic        out_claim;
	} ctl_state_t;

	typedef struct packed {
		logic [4:0]        step_cnt;
		logic [3:0]        phase;
		logic signed [2:0] offset;
	} dither_state_t;

endpackage : osc_pkg

// *** logic/osc_dither.sv ***
// stepped triangle generator for spread-spectrum dithering
`include "osc_params.svh"

module osc_dither (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              active,
	output logic signed [2:0]      offset
);

	osc_pkg::dither_state_t st_reg;
	osc_pkg::dither_state_t st_next;

	// ==========================================================
	// triangle shape: 0,1,2,3,2,1,0,-1,-2,-3,-2,-1
	function automatic logic signed [2:0] tri_of(input logic [3:0] ph);
		logic signed [4:0] v;
		v = 5'sh0;
		if (ph < 4'h4) begin
			v = $signed({1'b0, ph});
		end else if (ph < 4'ha) begin
			v = 5'sh6 - $signed({1'b0, ph});
		end else begin
			v = $signed({1'b0, ph}) - 5'shc;
		end
		return v[2:0];
	endfunction : tri_of

	// ==========================================================
	always_comb begin
		st_next = st_reg;
		if (!active) begin
			st_next = '0;
		end else begin
			// [R18] step every 32
			if (st_reg.step_cnt == 5'(`DITHER_STEP_CYC - 1)) begin
				st_next.step_cnt = 5'h0;
				// [R17] 384-cycle period
				if (st_reg.phase == 4'(`DITHER_PHASES - 1)) begin
					st_next.phase = 4'h0;
				end else begin
					st_next.phase = st_reg.phase + 4'h1;
				end
				st_next.offset = tri_of(st_next.phase);
			end else begin
				st_next.step_cnt = st_reg.step_cnt + 5'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign offset = st_reg.offset;

	// [R18] step spacing check
	step_every_a: assert property (@(posedge clk) disable iff (rst) // [R18]
		$changed(offset) && $past(active) && !$past(rst)
		|-> $past(st_reg.step_cnt) == 5'(`DITHER_STEP_CYC - 1))
		else $error("dither step off its 32-cycle grid");

	// [R17] period wrap check
	phase_wrap_a: assert property (@(posedge clk) disable iff (rst) // [R17]
		active && st_reg.phase == 4'(`DITHER_PHASES - 1)
		&& st_reg.step_cnt == 5'(`DITHER_STEP_CYC - 1) && $past(active)
		|=> !active || st_reg.phase == 4'h0)
		else $error("triangle period not twelve steps");

endmodule : osc_dither

// *** logic/internal_osc_control.sv ***
// control and status of the internal high-frequency oscillator
//
// What this block and its software do
// [R1] bit 7 enables the oscillator
// [R2] bit 6 reads frequency ready
// [R3] writing bit 5 suspends the oscillator
// [R4] enabled wake event restarts suspended oscillator
// [R5] bit 4 flags timer registers unsafe
// [R6] software avoids timer while bit 4 set
// [R7] bit 3 enables spread-spectrum dithering
// [R8] bit 2 reads zero, writes ignored
// [R9] bits 1:0 select divide 8/4/2/1
// [R10] software picks external mode and range
// [R11] crystal mode claims both oscillator pins
// [R12] other external modes claim output pin
// [R13] software makes crossbar skip claimed pins
// [R14] software sets analog inputs for those
// [R15] software sets digital input for cmos
// [R16] reset selects divide by eight
// [R17] dither triangle period is 384 cycles
// [R18] dither steps every 32 cycles
// [R19] ready low while off, high after settling
`include "osc_params.svh"

module internal_osc_control #(
	parameter int SETTLE_CYCLES = `SETTLE_CYC
) (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire osc_pkg::sfr_req_t sfr_req,
	output logic [7:0]             sfr_rdata,
	input  wire logic              wake_event,
	input  wire logic              wake_by_timer,
	input  wire logic              timer_clk_tick,
	input  wire logic [2:0]        ext_osc_mode,
	output logic                   osc_run,
	output logic                   hf_freq_ready,
	output logic                   wake_timer_sync_busy,
	output logic                   system_clock,
	output logic signed [2:0]      dither_offset,
	output logic                   osc_in_claim,
	output logic                   osc_out_claim
);

	osc_pkg::ctl_state_t st_reg;
	osc_pkg::ctl_state_t st_next;

	logic hit;
	logic wr_hit;
	logic rd_hit;

	// ==========================================================
	// helpers
	function automatic logic [2:0] div_reload(input logic [1:0] code);
		logic [2:0] r;
		r = 3'h0;
		case (code)
			`DIV_BY8: r = 3'h7;
			`DIV_BY4: r = 3'h3;
			`DIV_BY2: r = 3'h1;
			`DIV_BY1: r = 3'h0;
			default:  r = 3'h7;
		endcase
		return r;
	endfunction : div_reload

	function automatic logic [7:0] ctrl_image(input osc_pkg::ctl_state_t s);
		logic [7:0] v;
		v = 8'h00;
		v[`BIT_EN]   = s.ctrl.en;
		v[`BIT_RDY]  = s.ready;
		v[`BIT_SUSP] = (s.state == osc_pkg::OSC_SUSP);
		v[`BIT_SYNC] = s.sync_busy;
		v[`BIT_SSE]  = s.ctrl.spread_dither_enable;
		// [R8] reserved bit zero
		v[`BIT_RSVD] = 1'b0;
		v[`DIV_HI:`DIV_LO] = s.ctrl.div;
		return v;
	endfunction : ctrl_image

	// ==========================================================
	// register bus decode
	assign hit    = (sfr_req.addr == `OSC_CTRL_ADDR);
	assign wr_hit = hit && sfr_req.wr;
	assign rd_hit = hit && sfr_req.rd;

	// ==========================================================
	// next state
	always_comb begin
		st_next = st_reg;

		if (wr_hit) begin
			// [R1] enable bit
			st_next.ctrl.en  = sfr_req.wdata[`BIT_EN];
			// [R7] dither enable
			st_next.ctrl.spread_dither_enable = sfr_req.wdata[`BIT_SSE];
			// [R9] divider select
			st_next.ctrl.div = sfr_req.wdata[`DIV_HI:`DIV_LO];
		end

		case (st_reg.state)
			osc_pkg::OSC_OFF: begin
				if (st_next.ctrl.en) begin
					st_next.state      = osc_pkg::OSC_SETTLE;
					st_next.settle_cnt = 16'(SETTLE_CYCLES - 1);
				end
			end
			osc_pkg::OSC_SETTLE: begin
				if (!st_next.ctrl.en) begin
					st_next.state = osc_pkg::OSC_OFF;
				end else if (st_reg.settle_cnt == 16'h0) begin
					st_next.state = osc_pkg::OSC_RUN;
				end else begin
					st_next.settle_cnt = st_reg.settle_cnt - 16'h1;
				end
			end
			osc_pkg::OSC_RUN: begin
				if (!st_next.ctrl.en) begin
					st_next.state = osc_pkg::OSC_OFF;
				// [R3] suspend entry
				end else if (wr_hit && sfr_req.wdata[`BIT_SUSP]) begin
					st_next.state = osc_pkg::OSC_SUSP;
				end
			end
			osc_pkg::OSC_SUSP: begin
				if (!st_next.ctrl.en) begin
					st_next.state = osc_pkg::OSC_OFF;
				// [R4] wake without a write
				end else if (wake_event) begin
					st_next.state      = osc_pkg::OSC_SETTLE;
					st_next.settle_cnt = 16'(SETTLE_CYCLES - 1);
				end
			end
			default: begin
				st_next.state = osc_pkg::OSC_OFF;
			end
		endcase

		// [R19] ready only after settling
		st_next.ready = (st_next.state == osc_pkg::OSC_RUN);
		st_next.run   = (st_next.state == osc_pkg::OSC_RUN);

		// [R5] timer sync window
		if (st_next.state == osc_pkg::OSC_SUSP) begin
			// timer keeps its own clock while suspended, so hold it off limits
			st_next.sync_busy = 1'b1;
			st_next.sync_cnt  = `SYNC_TIMER_CLKS;
		end else if (st_reg.state == osc_pkg::OSC_SUSP) begin
			st_next.sync_busy = !wake_by_timer;
			st_next.sync_cnt  = `SYNC_TIMER_CLKS;
		end else if (st_reg.sync_busy && timer_clk_tick) begin
			// busy ends on the third timer clock, never later
			if (st_reg.sync_cnt == 2'h1) begin
				st_next.sync_busy = 1'b0;
			end
			st_next.sync_cnt = st_reg.sync_cnt - 2'h1;
		end

		// [R9] post-divider tick
		st_next.sys_tick = 1'b0;
		if (!st_next.run) begin
			st_next.div_cnt = 3'h0;
		end else if (st_reg.div_cnt == 3'h0) begin
			st_next.sys_tick = 1'b1;
			st_next.div_cnt  = div_reload(st_next.ctrl.div);
		end else begin
			st_next.div_cnt = st_reg.div_cnt - 3'h1;
		end

		// [R11] crystal claims both pins
		st_next.in_claim  = (ext_osc_mode[2:1] == `XMODE_XTAL);
		// [R12] any enabled mode claims output pin
		st_next.out_claim = (ext_osc_mode[2:1] != `XMODE_OFF);

		// [R2] status readback
		if (rd_hit) begin
			st_next.rdata = ctrl_image(st_reg);
		end else if (sfr_req.rd) begin
			st_next.rdata = 8'h00;
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge clk) begin
		if (rst) begin
			st_reg <= '0;
			// [R16] reset divide by eight
			st_reg.ctrl.en  <= `RST_EN;
			st_reg.ctrl.spread_dither_enable <= `RST_SSE;
			st_reg.ctrl.div <= `RST_DIV;
			// comes out of reset running and settled
			st_reg.state    <= osc_pkg::OSC_RUN;
			st_reg.ready    <= 1'b1;
			st_reg.run      <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// ==========================================================
	// dither generator
	osc_dither u_dither (
		.clk    (clk),
		.rst    (rst),
		.active (st_reg.run && st_reg.ctrl.spread_dither_enable),
		.offset (dither_offset)
	);

	// ==========================================================
	// outputs
	assign sfr_rdata            = st_reg.rdata;
	assign osc_run              = st_reg.run;
	assign hf_freq_ready        = st_reg.ready;
	assign wake_timer_sync_busy = st_reg.sync_busy;
	assign system_clock         = st_reg.sys_tick;
	assign osc_in_claim         = st_reg.in_claim;
	assign osc_out_claim        = st_reg.out_claim;

	// ==========================================================
	// checks
	sequence suspended_wake_s;
		st_reg.state == osc_pkg::OSC_SUSP && st_reg.ctrl.en && wake_event && !wr_hit;
	endsequence

	sequence settles_s;
		!hf_freq_ready ##[1:300] hf_freq_ready;
	endsequence

	// [R16] divide after reset
	reset_div_a: assert property (@(posedge clk) disable iff (rst) // [R16]
		$fell(rst) |-> st_reg.ctrl.div == `DIV_BY8)
		else $error("divider not eight after reset");

	// [R1] disable stops the oscillator
	enable_off_a: assert property (@(posedge clk) disable iff (rst) // [R1]
		wr_hit && !sfr_req.wdata[`BIT_EN] |=> !osc_run && !hf_freq_ready)
		else $error("oscillator still running after disable");

	// [R19] ready tracks running
	ready_low_a: assert property (@(posedge clk) disable iff (rst) // [R19]
		!st_reg.ctrl.en || st_reg.state == osc_pkg::OSC_SUSP
		|-> !hf_freq_ready && !osc_run)
		else $error("ready flag disagrees with oscillator state");

	// [R3] suspend write stops output
	suspend_entry_a: assert property (@(posedge clk) disable iff (rst) // [R3]
		wr_hit && sfr_req.wdata[`BIT_EN] && sfr_req.wdata[`BIT_SUSP] && osc_run
		|=> (!osc_run && st_reg.state == osc_pkg::OSC_SUSP)
		##1 !system_clock)
		else $error("suspend write did not stop oscillator");

	// [R4] wake restarts and settles
	wake_restart_a: assert property (@(posedge clk) disable iff (rst) // [R4]
		suspended_wake_s |=> settles_s)
		else $error("wake event did not restart oscillator");

	// [R5] timer wake clears sync at once
	sync_timer_a: assert property (@(posedge clk) disable iff (rst) // [R5]
		suspended_wake_s and wake_by_timer |=> !wake_timer_sync_busy)
		else $error("sync busy after timer wake");

	// [R5] sync window bounded
	sync_bound_a: assert property (@(posedge clk) disable iff (rst) // [R5]
		wake_timer_sync_busy && st_reg.state != osc_pkg::OSC_SUSP
		&& timer_clk_tick && st_reg.sync_cnt == 2'h1 |=> !wake_timer_sync_busy)
		else $error("sync busy past three timer clocks");

	// [R7] no dither when disabled
	dither_off_a: assert property (@(posedge clk) disable iff (rst) // [R7]
		!st_reg.ctrl.spread_dither_enable ##1 !st_reg.ctrl.spread_dither_enable |-> dither_offset == 3'sh0)
		else $error("dither active while disabled");

	// [R9] divide by one ticks each cycle
	div_one_a: assert property (@(posedge clk) disable iff (rst) // [R9]
		(osc_run && st_reg.div_cnt == 3'h0) ##1 osc_run |-> system_clock)
		else $error("post-divider tick missing");

	// [R8] reserved bit reads zero
	rsvd_zero_a: assert property (@(posedge clk) disable iff (rst) // [R8]
		sfr_rdata[`BIT_RSVD] == 1'b0)
		else $error("reserved bit read as one");

	// [R2] readback shows ready flag
	ready_read_a: assert property (@(posedge clk) disable iff (rst) // [R2]
		rd_hit |=> sfr_rdata[`BIT_RDY] == $past(hf_freq_ready))
		else $error("ready bit readback wrong");

	// [R3] suspended state reads back
	susp_read_a: assert property (@(posedge clk) disable iff (rst) // [R3]
		rd_hit && st_reg.state == osc_pkg::OSC_SUSP
		|=> sfr_rdata[`BIT_SUSP] && sfr_rdata[`BIT_SYNC] && !sfr_rdata[`BIT_RDY])
		else $error("suspend status readback wrong");

	// [R19] ready rises only from settling
	ready_rise_a: assert property (@(posedge clk) disable iff (rst) // [R19]
		$rose(hf_freq_ready) && !$past(rst) |-> $past(st_reg.state) == osc_pkg::OSC_SETTLE)
		else $error("ready rose without settling");

	// [R11] crystal pin claim
	xtal_claim_a: assert property (@(posedge clk) disable iff (rst) // [R11]
		ext_osc_mode[2:1] == `XMODE_XTAL |=> osc_in_claim && osc_out_claim)
		else $error("crystal mode did not claim both pins");

	// [R12] single pin claim
	one_pin_a: assert property (@(posedge clk) disable iff (rst) // [R12]
		ext_osc_mode[2:1] != `XMODE_OFF && ext_osc_mode[2:1] != `XMODE_XTAL
		|=> !osc_in_claim && osc_out_claim)
		else $error("single pin mode claim wrong");

endmodule : internal_osc_control

// *** tb/wake_source_model.sv ***
// wake-up source model: timer clock, wake events and external oscillator mode
module wake_source_model #(
	parameter int TICK_DIV = 5
) (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       wake_req,
	input  wire logic       by_timer,
	input  wire logic [2:0] mode_sel,
	output logic            wake_event,
	output logic            wake_by_timer,
	output logic            timer_clk_tick,
	output logic [2:0]      ext_osc_mode
);
	timeunit 1ns;
	timeprecision 1ps;
	int div_cnt;

	// ==========================================================
	// timer clock and wake sources
	always @(posedge clk) begin
		if (rst) begin
			div_cnt <= 0;
			timer_clk_tick <= 1'b0;
		end else begin
			div_cnt <= (div_cnt == TICK_DIV - 1) ? 0 : div_cnt + 1;
			timer_clk_tick <= (div_cnt == TICK_DIV - 1);
		end
		wake_event <= wake_req;
		// qualifier low outside a wake, never a stale value
		wake_by_timer <= wake_req & by_timer;
		ext_osc_mode <= mode_sel;
	end
endmodule : wake_source_model

// *** tb/internal_osc_control_test.sv ***
// self-checking bench of the internal oscillator control block
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
	$display("MISMATCH %s exp %h got %h", nm, e, g); end end
module internal_osc_control_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SETTLE = 4;
	typedef struct packed {
		logic [7:0] wd;
		logic [7:0] rd;
		logic [3:0] per;
	} row_t;
	logic              clk        = 1'b0;
	logic              rst        = 1'b1;
	osc_pkg::sfr_req_t req        = '0;
	logic              wake_req   = 1'b0;
	logic              by_timer   = 1'b0;
	logic [2:0]        mode_sel   = 3'h0;
	logic [7:0]        sfr_rdata;
	logic              osc_run, ready, busy, sys_clk, in_claim, out_claim;
	logic              wk, wkt, tick;
	logic [2:0]        xmode;
	logic signed [2:0] doff;
	int                bad_count  = 0;
	int                num_checks = 0;
	row_t rows [5] = '{'{8'h83, 8'hc3, 4'h1}, '{8'h86, 8'hc2, 4'h2},
		'{8'hd1, 8'hc1, 4'h4}, '{8'h89, 8'hc9, 4'h4}, '{8'h84, 8'hc0, 4'h8}};

	always #2 clk = ~clk;

	wake_source_model u_src (.clk(clk), .rst(rst), .wake_req(wake_req), .by_timer(by_timer),
		.mode_sel(mode_sel), .wake_event(wk), .wake_by_timer(wkt), .timer_clk_tick(tick),
		.ext_osc_mode(xmode));

	internal_osc_control #(.SETTLE_CYCLES(SETTLE)) u_dut (.clk(clk), .rst(rst),
		.sfr_req(req), .sfr_rdata(sfr_rdata), .wake_event(wk), .wake_by_timer(wkt),
		.timer_clk_tick(tick), .ext_osc_mode(xmode), .osc_run(osc_run),
		.hf_freq_ready(ready), .wake_timer_sync_busy(busy), .system_clock(sys_clk),
		.dither_offset(doff), .osc_in_claim(in_claim), .osc_out_claim(out_claim));

	// ==========================================================
	// closing report
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : results

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step

	task automatic give_up();
		bad_count++;
		$display("MISMATCH wait exceeded its bound");
		results();
	endtask : give_up

	// ==========================================================
	// register access, data held until the taking edge
	task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
		@(posedge clk);
		req <= '0;
		#1;
	endtask : sfr_wr

	task automatic sfr_rd(input logic [7:0] a, output logic [7:0] q);
		@(posedge clk);
		req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
		@(posedge clk);
		req <= '0;
		#1;
		q = sfr_rdata;
	endtask : sfr_rd

	task automatic wait_hi(ref logic s, input int lim, output int n);
		n = 0;
		while (s !== 1'b1) begin
			step(1);
			n++;
			if (n > lim) give_up();
		end
	endtask : wait_hi

	task automatic count_ticks(input int cyc, output int p);
		p = 0;
		repeat (cyc) begin
			step(1);
			if (sys_clk === 1'b1) p++;
		end
	endtask : count_ticks

	task automatic wait_chg(output int n);
		logic signed [2:0] o;
		o = doff;
		n = 0;
		while (doff === o) begin
			step(1);
			n++;
			if (n > 40) give_up();
		end
	endtask : wait_chg

	task automatic wake(input logic tmr);
		@(posedge clk);
		wake_req <= 1'b1;
		by_timer <= tmr;
		@(posedge clk);
		wake_req <= 1'b0;
		@(posedge clk);
		#1;
	endtask : wake

	initial begin
		repeat (100000) @(posedge clk);
		give_up();
	end

	// ==========================================================
	// main sequence
	initial begin
		int n;
		int p;
		int c;
		logic [7:0] q;
		logic signed [2:0] d0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		#1;
		`CHK("ready", 1'b1, ready)
		`CHK("busy", 1'b0, busy)
		sfr_rd(8'hb2, q);
		`CHK("reset value", 8'hc0, q)
		foreach (rows[i]) begin
			sfr_wr(8'hb2, rows[i].wd);
			sfr_rd(8'hb2, q);
			`CHK("control", rows[i].rd, q)
			wait_hi(sys_clk, 16, n);
			step(1);
			wait_hi(sys_clk, 16, n);
			`CHK("system_clock period", rows[i].per, 4'(n + 1))
		end
		sfr_wr(8'hb3, 8'h00);
		sfr_rd(8'hb2, q);
		`CHK("foreign write", 8'hc0, q)
		sfr_rd(8'hb3, q);
		`CHK("foreign read", 8'h00, q)
		sfr_wr(8'hb2, 8'h88);
		wait_chg(n);
		wait_chg(n);
		`CHK("dither step", 32, n)
		d0 = doff;
		step(192);
		`CHK("dither half", -d0, doff)
		step(192);
		`CHK("dither period", d0, doff)
		sfr_wr(8'hb2, 8'h80);
		step(40);
		`CHK("dither off", 3'sd0, doff)
		sfr_wr(8'hb2, 8'h00);
		`CHK("ready off", 1'b0, ready)
		count_ticks(16, p);
		`CHK("ticks off", 0, p)
		sfr_wr(8'hb2, 8'h80);
		wait_hi(ready, SETTLE + 10, n);
		// ready shows settle_cycles edges after the enabling write edge
		`CHK("settle", SETTLE, n)
		sfr_wr(8'hb2, 8'ha0);
		`CHK("busy susp", 1'b1, busy)
		sfr_rd(8'hb2, q);
		`CHK("suspend read", 8'hb0, q)
		count_ticks(16, p);
		`CHK("ticks susp", 0, p)
		wake(1'b0);
		c = 0;
		n = 0;
		while (busy === 1'b1) begin
			if (tick === 1'b1) c++;
			step(1);
			n++;
			if (n > 60) give_up();
		end
		`CHK("sync ticks", 3, c)
		wait_hi(ready, SETTLE + 40, n);
		`CHK("woken", 1'b1, osc_run)
		sfr_wr(8'hb2, 8'ha0);
		wake(1'b1);
		step(1);
		`CHK("busy timer", 1'b0, busy)
		wait_hi(ready, SETTLE + 10, n);
		// one of the settle edges has already passed in the step above
		`CHK("wake settle", SETTLE - 1, n)
		for (int m = 0; m < 8; m++) begin
			@(posedge clk);
			mode_sel <= 3'(m);
			step(3);
			`CHK("in claim", (m / 2 == 3), in_claim)
			`CHK("out claim", (m / 2 != 0), out_claim)
		end
		sfr_wr(8'hb2, 8'h8b);
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		#1;
		sfr_rd(8'hb2, q);
		`CHK("rerun reset", 8'hc0, q)
		results();
	end
endmodule : internal_osc_control_test
